// ### rtl/system_clock_mode_controller.sv
// System clock and operating mode controller with AHB-Lite registers.
// Assumes fast clock equals i_clk; slow clock arrives on an async pin.
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "clk_mode_consts.svh"
module system_clock_mode_controller import clk_mode_pkg::*; (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_slow_xtal_in,
   input wire logic i_irq_req,
   input wire logic i_master_irq_enable,
   input wire logic i_base_timer_irq_enable,
   input wire logic i_deep_stop,
   input wire logic i_stop_warmup,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   output logic o_main_tick,
   output logic [1:0] o_machine_state,
   output logic o_cpu_run,
   output logic o_watchdog_run,
   output logic o_periph_clk_en,
   output logic o_fast_osc_on,
   output logic o_slow_osc_on,
   output logic o_slow_pins_port,
   output logic o_wake_service,
   output logic o_wake_resume,
   output logic o_base_timer_irq_take,
   output logic [22:0] o_divider
);
   // ----------------------------------------------------------------------
   // Slow clock pin synchroniser
   // ----------------------------------------------------------------------
   logic slow_s1_ff, slow_s2_ff, slow_s3_ff;
   logic slow_rise;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         slow_s1_ff <= 1'b0;
         slow_s2_ff <= 1'b0;
         slow_s3_ff <= 1'b0;
      end else begin
         slow_s1_ff <= i_slow_xtal_in;
         slow_s2_ff <= slow_s1_ff;
         slow_s3_ff <= slow_s2_ff;
      end
   end
   assign slow_rise = slow_s2_ff & ~slow_s3_ff;

   // ----------------------------------------------------------------------
   // Bus slave and registers
   // ----------------------------------------------------------------------
   logic [4:0] ctrl_ff, nxt_ctrl;
   logic [4:0] btc_ff, nxt_btc;
   logic wr_ff, nxt_wr;
   logic [7:0] addr_ff, nxt_addr;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic irq_latch_ff, nxt_irq_latch;
   mode_t mode_ff, nxt_mode;
   logic [1:0] mstate_ff, nxt_mstate;
   logic accept, wait_taken, halt_taken, latch_set;

   assign accept = i_hsel & i_hready & i_htrans[1];

   always_comb begin
      nxt_wr = 1'b0;
      nxt_addr = addr_ff;
      nxt_hrdata = hrdata_ff;
      nxt_ctrl = ctrl_ff;
      nxt_btc = btc_ff;
      nxt_irq_latch = irq_latch_ff | latch_set;
      // Requests clear once the mode machine takes them
      if (wait_taken) begin
         nxt_ctrl[`SC_WAIT_REQ] = 1'b0;
      end
      if (halt_taken) begin
         nxt_ctrl[`SC_GATE_HALT] = 1'b0;
      end
      if (wr_ff) begin
         if (addr_ff == `SYS_CTRL_TWO_OFS) begin
            nxt_ctrl[2:0] = i_hwdata[2:0];
            // Write one only; a write of zero never cancels a pending request
            if (i_hwdata[`SC_WAIT_REQ]) begin
               nxt_ctrl[`SC_WAIT_REQ] = 1'b1;
            end
            if (i_hwdata[`SC_GATE_HALT]) begin
               nxt_ctrl[`SC_GATE_HALT] = 1'b1;
            end
         end else if (addr_ff == `BASE_TIMER_CTRL_OFS) begin
            nxt_btc = i_hwdata[4:0];
         end else if (addr_ff == `MODE_STATUS_OFS) begin
            // Set beats clear in the same cycle
            if (i_hwdata[`ST_IRQ_LATCH] && !latch_set) begin
               nxt_irq_latch = 1'b0;
            end
         end
      end
      if (accept) begin
         nxt_wr = i_hwrite;
         nxt_addr = i_haddr[7:0];
         if (i_haddr[7:0] == `SYS_CTRL_TWO_OFS) begin
            nxt_hrdata = {27'h000_0000, ctrl_ff};
         end else if (i_haddr[7:0] == `BASE_TIMER_CTRL_OFS) begin
            nxt_hrdata = {27'h000_0000, btc_ff};
         end else if (i_haddr[7:0] == `MODE_STATUS_OFS) begin
            nxt_hrdata = {22'h00_0000, irq_latch_ff, mstate_ff, mode_ff};
         end else begin
            nxt_hrdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ff <= 1'b0;
         addr_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
         ctrl_ff <= `SYS_CTRL_TWO_RST;
         btc_ff <= `BASE_TIMER_CTRL_RST;
         irq_latch_ff <= 1'b0;
      end else begin
         wr_ff <= nxt_wr;
         addr_ff <= nxt_addr;
         hrdata_ff <= nxt_hrdata;
         ctrl_ff <= nxt_ctrl;
         btc_ff <= nxt_btc;
         irq_latch_ff <= nxt_irq_latch;
      end
   end

   // ----------------------------------------------------------------------
   // Machine cycle and mode sequencer
   // ----------------------------------------------------------------------
   logic is_slow, main_adv, boundary, tbt_fall, wake_req;
   logic bt_wake_ff, nxt_bt_wake;
   logic bt_armed_ff, nxt_bt_armed;
   logic svc_ff, nxt_svc, res_ff, nxt_res;

   assign is_slow = (mode_ff == slow_run_fast_osc_on) || (mode_ff == slow_run_fast_osc_off);
   // Fast modes step every fast clock; slow modes on each slow rising edge
   assign main_adv = is_slow ? slow_rise : 1'b1;
   assign boundary = main_adv && (mstate_ff == 2'd3);
   assign wake_req = i_irq_req;

   always_comb begin
      nxt_mstate = mstate_ff;
      if (main_adv) begin
         nxt_mstate = mstate_ff + 2'd1;
      end
   end

   always_comb begin
      nxt_mode = mode_ff;
      nxt_bt_wake = bt_wake_ff | tbt_fall;
      nxt_bt_armed = bt_armed_ff;
      nxt_svc = 1'b0;
      nxt_res = 1'b0;
      wait_taken = 1'b0;
      halt_taken = 1'b0;
      latch_set = 1'b0;
      // Switching only at the end of state three keeps every clock whole
      if (boundary) begin
         case (mode_ff)
            fast_run_single: begin
               if (ctrl_ff[`SC_GATE_HALT]) begin
                  nxt_mode = base_timer_wait_single;
                  halt_taken = 1'b1;
                  nxt_bt_wake = 1'b0;
                  nxt_bt_armed = btc_ff[`BT_ENABLE];
               end else if (ctrl_ff[`SC_WAIT_REQ]) begin
                  nxt_mode = fast_wait_single;
                  wait_taken = 1'b1;
               end else if (ctrl_ff[`SC_SLOW_OSC_EN]) begin
                  nxt_mode = fast_run_dual;
               end
            end
            fast_wait_single: begin
               if (wake_req) begin
                  nxt_mode = fast_run_single;
                  nxt_svc = i_master_irq_enable;
                  nxt_res = ~i_master_irq_enable;
               end
            end
            base_timer_wait_single: begin
               if (bt_wake_ff) begin
                  nxt_mode = fast_run_single;
                  latch_set = bt_armed_ff;
                  nxt_bt_armed = 1'b0;
               end
            end
            fast_run_dual: begin
               if (ctrl_ff[`SC_WAIT_REQ]) begin
                  nxt_mode = fast_wait_dual;
                  wait_taken = 1'b1;
               end else if (ctrl_ff[`SC_SLOW_CLK_SEL]) begin
                  nxt_mode = slow_run_fast_osc_on;
               end else if (!ctrl_ff[`SC_SLOW_OSC_EN]) begin
                  nxt_mode = fast_run_single;
               end
            end
            fast_wait_dual: begin
               if (wake_req) begin
                  nxt_mode = fast_run_dual;
                  nxt_svc = i_master_irq_enable;
                  nxt_res = ~i_master_irq_enable;
               end
            end
            slow_run_fast_osc_on: begin
               if (!ctrl_ff[`SC_SLOW_CLK_SEL]) begin
                  nxt_mode = fast_run_dual;
               end else if (!ctrl_ff[`SC_FAST_OSC_EN]) begin
                  nxt_mode = slow_run_fast_osc_off;
               end
            end
            slow_run_fast_osc_off: begin
               if (ctrl_ff[`SC_FAST_OSC_EN]) begin
                  nxt_mode = slow_run_fast_osc_on;
               end
            end
            default: begin
               nxt_mode = fast_run_single;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_ff <= fast_run_single;
         mstate_ff <= 2'd0;
         bt_wake_ff <= 1'b0;
         bt_armed_ff <= 1'b0;
         svc_ff <= 1'b0;
         res_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         mstate_ff <= nxt_mstate;
         bt_wake_ff <= nxt_bt_wake;
         bt_armed_ff <= nxt_bt_armed;
         svc_ff <= nxt_svc;
         res_ff <= nxt_res;
      end
   end

   // ----------------------------------------------------------------------
   // Prescaler and divider
   // ----------------------------------------------------------------------
   localparam int LOW_W = `PRESCALE_STAGES + `LOW_DIV_STAGES;
   logic [LOW_W-1:0] low_ff, nxt_low;
   logic [`HIGH_DIV_STAGES-1:0] high_ff, nxt_high;
   logic stop_ff, warm_fast_ff, nxt_warm_fast, tap_ff, nxt_tap;
   logic low_run, stage6_out, stage7_in, stop_edge, is_fast;

   assign is_fast = (mode_ff == fast_run_single) || (mode_ff == fast_run_dual);
   // Slow run with fast oscillator off starves stages one to six
   assign low_run = (mode_ff != slow_run_fast_osc_off);
   assign stage6_out = low_run && (&low_ff);
   assign stop_edge = i_deep_stop ^ stop_ff;

   always_comb begin
      stage7_in = stage6_out;
      if (is_slow) begin
         stage7_in = slow_rise;
      end else if (i_stop_warmup && warm_fast_ff) begin
         stage7_in = stage6_out;
      end else if (btc_ff[`BT_STAGE7_SEL]) begin
         // Relies on software keeping this clear in single mode
         stage7_in = slow_rise;
      end
   end

   always_comb begin
      nxt_low = low_ff;
      nxt_high = high_ff;
      nxt_warm_fast = warm_fast_ff;
      if (stop_edge && i_deep_stop) begin
         nxt_warm_fast = is_fast;
      end
      if (stop_edge) begin
         nxt_low = '0;
         nxt_high = '0;
      end else begin
         if (low_run) begin
            nxt_low = low_ff + 1'b1;
         end
         if (stage7_in) begin
            nxt_high = high_ff + 1'b1;
         end
      end
      nxt_tap = high_ff[{btc_ff[2:0], 1'b0}];
   end
   assign tbt_fall = tap_ff && !high_ff[{btc_ff[2:0], 1'b0}];

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         low_ff <= '0;
         high_ff <= '0;
         stop_ff <= 1'b0;
         warm_fast_ff <= 1'b0;
         tap_ff <= 1'b0;
      end else begin
         low_ff <= nxt_low;
         high_ff <= nxt_high;
         stop_ff <= i_deep_stop;
         warm_fast_ff <= nxt_warm_fast;
         tap_ff <= nxt_tap;
      end
   end

   // ----------------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------------
   logic single_mode;
   assign single_mode = (mode_ff == fast_run_single) || (mode_ff == fast_wait_single)
      || (mode_ff == base_timer_wait_single);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_main_tick <= 1'b0;
         o_machine_state <= 2'd0;
         o_cpu_run <= 1'b1;
         o_watchdog_run <= 1'b1;
         o_periph_clk_en <= 1'b1;
         o_fast_osc_on <= 1'b1;
         o_slow_osc_on <= 1'b0;
         o_slow_pins_port <= 1'b1;
         o_wake_service <= 1'b0;
         o_wake_resume <= 1'b0;
         o_base_timer_irq_take <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_main_tick <= main_adv;
         o_machine_state <= nxt_mstate;
         o_cpu_run <= (nxt_mode == fast_run_single) || (nxt_mode == fast_run_dual)
            || (nxt_mode == slow_run_fast_osc_on) || (nxt_mode == slow_run_fast_osc_off);
         o_watchdog_run <= (nxt_mode != fast_wait_single) && (nxt_mode != fast_wait_dual)
            && (nxt_mode != base_timer_wait_single);
         o_periph_clk_en <= (nxt_mode != base_timer_wait_single);
         o_fast_osc_on <= (nxt_mode != slow_run_fast_osc_off);
         o_slow_osc_on <= ctrl_ff[`SC_SLOW_OSC_EN] && !single_mode;
         o_slow_pins_port <= single_mode;
         // One cycle behind the mode change, so the CPU sees run first
         o_wake_service <= svc_ff;
         o_wake_resume <= res_ff;
         o_base_timer_irq_take <= nxt_irq_latch && i_master_irq_enable
            && i_base_timer_irq_enable && btc_ff[`BT_ENABLE];
      end
   end
   assign o_hrdata = hrdata_ff;
   assign o_divider = {high_ff, low_ff};

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   mode_on_boundary_a: assert property ($changed(mode_ff) |-> $past(boundary))
      else $error("Mode changed off a cycle boundary");
   state_step_a: assert property (main_adv |=> mstate_ff == $past(mstate_ff) + 2'd1)
      else $error("Machine state did not step");
   wait_entry_a: assert property (boundary && mode_ff == fast_run_single
      && ctrl_ff[`SC_WAIT_REQ] && !ctrl_ff[`SC_GATE_HALT] |=> mode_ff == fast_wait_single)
      else $error("Wait request not taken");
   wait_wake_a: assert property (boundary && mode_ff == fast_wait_single && wake_req
      |=> mode_ff == fast_run_single ##1 (o_wake_service ^ o_wake_resume))
      else $error("Wait not released by request");
   halt_gate_a: assert property (mode_ff == base_timer_wait_single |-> !o_periph_clk_en)
      else $error("Peripheral clocks not withheld");
   bt_latch_a: assert property (boundary && mode_ff == base_timer_wait_single
      && bt_wake_ff && bt_armed_ff |=> irq_latch_ff)
      else $error("Base timer latch not set");
   slow_stage7_a: assert property (is_slow && !stop_edge
      |=> high_ff == $past(high_ff) + $past(slow_rise))
      else $error("Stage seven not fed slow clock");
   low_stop_a: assert property (mode_ff == slow_run_fast_osc_off && !stop_edge
      |=> low_ff == $past(low_ff))
      else $error("Low divider ran with fast oscillator off");
   stop_clear_a: assert property (stop_edge |=> low_ff == '0 && high_ff == '0)
      else $error("Divider not cleared on stop edge");
   slow_entry_a: assert property (boundary && mode_ff == fast_run_dual
      && !ctrl_ff[`SC_WAIT_REQ] && ctrl_ff[`SC_SLOW_CLK_SEL]
      |=> mode_ff == slow_run_fast_osc_on)
      else $error("Slow select not honoured");

   base_wait_c: cover property (mode_ff == base_timer_wait_single ##[1:1000] mode_ff == fast_run_single);
   slow_off_c: cover property (mode_ff == slow_run_fast_osc_off);
   wake_svc_c: cover property (o_wake_service);
   dual_wait_c: cover property (mode_ff == fast_wait_dual ##1 mode_ff == fast_run_dual);
endmodule

// ### rtl/clk_mode_consts.svh
// Register offsets, field positions, reset values and timing figures
// for the system clock and operating mode controller.
// Assumes a 32-bit AHB-Lite slave and a 200 MHz bus clock.
//
// Functional notes
// - Timing generator has 2-stage prescaler, 21-stage divider, cycle counters.
// - Prescaler and divider clear on reset and on deep stop start or cancel.
// - Stage seven input depends on mode, slow select and stage-seven select.
// - Slow modes ignore stage-seven select and feed slow clock to stage seven.
// - Warm-up after stop from fast mode feeds stage six into stage seven.
// - Machine cycle is four states, zero to three, one main clock each.
// - Single-clock mode: fast oscillator only, slow pins are ports, 4 fast.
// - Reset enters single-clock fast run, everything clocked from fast clock.
// - Wait request enters single fast wait; CPU and watchdog halt.
// - Any interrupt request ends single fast wait, back to fast run.
// - On wake, enabled interrupts are serviced, else resume after wait.
// - Clock gate halt enters base-timer wait; only base timer clocked.
// - Base-timer source falling edge restores clocks, returns to fast run.
// - Base-timer wait works regardless of enable; irq needs all three enables.
// - Entered with base timer enabled, latch base timer irq after return.
// - Dual mode runs both oscillators; cycle is 4 fast or 4 slow.
// - Reset gives single mode; software enables slow oscillator first.
// - Dual fast run: CPU on fast clock, peripherals fast and/or slow.
// - Slow select one goes slow run fast-on; zero returns dual fast run.
// - Fast enable clear in slow run stops fast osc; set restores it.
// - Slow run fast-off stops divider stages one through six.
// - Dual fast wait keeps peripherals, halts CPU, wakes to dual fast run.
`ifndef CLK_MODE_CONSTS_SVH
`define CLK_MODE_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SYS_CTRL_TWO_OFS 8'h00
`define BASE_TIMER_CTRL_OFS 8'h04
`define MODE_STATUS_OFS 8'h08

`define SC_SLOW_OSC_EN 0
`define SC_FAST_OSC_EN 1
`define SC_SLOW_CLK_SEL 2
`define SC_WAIT_REQ 3
`define SC_GATE_HALT 4
`define SYS_CTRL_TWO_RST 5'h02

`define BT_CLK_SEL_LSB 0
`define BT_ENABLE 3
`define BT_STAGE7_SEL 4
`define BASE_TIMER_CTRL_RST 5'h00

`define ST_MODE_LSB 0
`define ST_MSTATE_LSB 7
`define ST_IRQ_LATCH 9

// ----------------------------------------------------------------------
// Timing generator
// ----------------------------------------------------------------------
`define PRESCALE_STAGES 2
`define LOW_DIV_STAGES 6
`define HIGH_DIV_STAGES 15
`define STATES_PER_CYCLE 4
`define CLK_PERIOD_PS 5000

`endif

// ### rtl/clk_mode_pkg.sv
// Types shared by the clock and mode controller.
// Assumes the constants header is included by users.
package clk_mode_pkg;
   typedef enum logic [6:0] {
      fast_run_single        = 7'b000_0001,
      fast_wait_single       = 7'b000_0010,
      base_timer_wait_single = 7'b000_0100,
      fast_run_dual          = 7'b000_1000,
      fast_wait_dual         = 7'b001_0000,
      slow_run_fast_osc_on   = 7'b010_0000,
      slow_run_fast_osc_off  = 7'b100_0000
   } mode_t;
endpackage

// ### tb/cpu_bus_partner.sv
// CPU side model: single-word AHB-Lite master driven by bench software.
// Assumes one slave whose hreadyout comes back on i_hready.
`timescale 1ns/1ps
`include "clk_mode_consts.svh"
module cpu_bus_partner (
   input wire logic i_clk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   output logic o_hsel,
   output logic [31:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [31:0] o_hwdata
);
   logic [31:0] ctrl_sh = 32'h0000_0002;
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0000_0000;
      o_htrans = 2'b00;
      o_hwrite = 1'b0;
      o_hsize = 3'b010;
      o_hwdata = 32'h0000_0000;
   end
   // -------------------------------------------------------------
   // Bus transfers, entered just after a rising edge
   // -------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      o_hsel <= 1'b1;
      o_haddr <= {24'h00_0000, a};
      o_htrans <= 2'b10;
      o_hwrite <= wr;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      o_htrans <= 2'b00;
      o_hwdata <= d;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      q = i_hrdata;
   endtask
   // Software side keeps its own control bit discipline
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dd;
      logic [31:0] q;
      dd = d;
      dd[0] = (a == `SYS_CTRL_TWO_OFS && ctrl_sh[2] && ctrl_sh[1]) ? 1'b1 : d[0];
      dd[4] = (a == `BASE_TIMER_CTRL_OFS && !ctrl_sh[0]) ? 1'b0 : d[4];
      ctrl_sh = (a == `SYS_CTRL_TWO_OFS) ? dd : ctrl_sh;
      xfer(1'b1, a, dd, q);
   endtask
endmodule

// ### tb/system_clock_mode_controller_tb_top.sv
// Bench: mode sequencing, wait wakes, halt wake, divider clear.
// Assumes the bus partner model and a bench-made slow crystal clock.
`timescale 1ns/1ps
`include "clk_mode_consts.svh"
module system_clock_mode_controller_tb_top import clk_mode_pkg::*;;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic slow_xtal = 1'b0;
   logic warm = 1'b0;
   logic irq_req, m_ie, bt_ie, deep_stop, hsel, hwrite, hready, hresp, tick;
   logic cpu_run, wd_run, pclk_en, fosc, sosc, sport, w_srv, w_res, bt_take;
   logic [1:0] htrans, mstate;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [22:0] divider;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   int sdiv = 0;
   mode_t mdl;
   always #2.5 clk = ~clk;
   // Slow crystal well below the fast clock; timeout counts cyc in the same block
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sdiv <= (sdiv == 11) ? 0 : sdiv + 1;
      slow_xtal <= (sdiv == 11) ? ~slow_xtal : slow_xtal;
      if (cyc == 60000) begin
         fails++;
         tally_and_finish();
      end
   end
   cpu_bus_partner u_cpu (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
      .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
      .o_hwdata(hwdata));
   system_clock_mode_controller u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hready), .i_slow_xtal_in(slow_xtal), .i_irq_req(irq_req),
      .i_master_irq_enable(m_ie), .i_base_timer_irq_enable(bt_ie), .i_deep_stop(deep_stop),
      .i_stop_warmup(warm), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
      .o_main_tick(tick), .o_machine_state(mstate), .o_cpu_run(cpu_run),
      .o_watchdog_run(wd_run), .o_periph_clk_en(pclk_en), .o_fast_osc_on(fosc),
      .o_slow_osc_on(sosc), .o_slow_pins_port(sport), .o_wake_service(w_srv),
      .o_wake_resume(w_res), .o_base_timer_irq_take(bt_take), .o_divider(divider));
   // -------------------------------------------------------------
   // Reference model and compares
   // -------------------------------------------------------------
   function automatic mode_t model(input mode_t m, input logic [31:0] c);
      case (m)
         fast_run_single: model = c[4] ? base_timer_wait_single : c[3] ? fast_wait_single :
            c[0] ? fast_run_dual : m;
         fast_run_dual: model = !c[0] ? fast_run_single : c[2] ? slow_run_fast_osc_on :
            c[3] ? fast_wait_dual : m;
         slow_run_fast_osc_on: model = !c[2] ? fast_run_dual : !c[1] ? slow_run_fast_osc_off : m;
         slow_run_fast_osc_off: model = c[1] ? slow_run_fast_osc_on : m;
         default: model = m;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pins(input mode_t m);
      logic r;
      r = m inside {fast_run_single, fast_run_dual, slow_run_fast_osc_on, slow_run_fast_osc_off};
      chk({26'h0, cpu_run, wd_run, pclk_en, fosc, sosc, sport}, {26'h0, r, r,
         m != base_timer_wait_single, m != slow_run_fast_osc_off, m >= fast_run_dual,
         m < fast_run_dual});
   endtask
   // Polls status, since slow modes reach a boundary only every four slow ticks
   task automatic wait_mode(input mode_t m);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         u_cpu.xfer(1'b0, `MODE_STATUS_OFS, 32'h0000_0000, q);
         n++;
      end while (q[6:0] !== m && n < 600);
      chk({25'h0, q[6:0]}, {25'h0, m});
      chk_pins(m);
      chk({30'h0, hready, hresp}, 32'h0000_0002);
   endtask
   task automatic set_ctl(input logic [31:0] d);
      u_cpu.wr(`SYS_CTRL_TWO_OFS, d);
      mdl = model(mdl, d);
      wait_mode(mdl);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic sv, rs;
      q = $urandom(32'h4754_617f);
      irq_req = 1'b0;
      m_ie = 1'b0;
      bt_ie = 1'b0;
      deep_stop = 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      mdl = fast_run_single;
      chk_pins(mdl);
      u_cpu.xfer(1'b0, `SYS_CTRL_TWO_OFS, 32'h0000_0000, q);
      chk(q, 32'h0000_0002);
      u_cpu.xfer(1'b0, 8'($urandom_range(3, 63) << 2), 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      #1;
      for (int i = 0; i < 8; i++) begin
         q[1:0] = mstate;
         @(posedge clk);
         #1;
         chk({29'h0, tick, mstate}, {29'h0, 1'b1, 2'(q[1:0] + 2'd1)});
      end
      @(posedge clk);
      for (int ie = 0; ie < 2; ie++) begin
         m_ie <= ie[0];
         set_ctl(32'h0000_000a);
         repeat ($urandom_range(1, 9)) @(posedge clk);
         irq_req <= 1'b1;
         sv = 1'b0;
         rs = 1'b0;
         repeat (16) begin
            @(posedge clk);
            #1;
            sv = sv | w_srv;
            rs = rs | w_res;
         end
         @(posedge clk);
         irq_req <= 1'b0;
         mdl = fast_run_single;
         wait_mode(mdl);
         chk({30'h0, sv, rs}, {30'h0, ie[0], !ie[0]});
      end
      u_cpu.wr(`BASE_TIMER_CTRL_OFS, 32'h0000_0008);
      m_ie <= 1'b1;
      bt_ie <= 1'b1;
      set_ctl(32'h0000_0012);
      mdl = fast_run_single;
      wait_mode(mdl);
      u_cpu.xfer(1'b0, `MODE_STATUS_OFS, 32'h0000_0000, q);
      chk({31'h0, q[9]}, 32'h0000_0001);
      chk({31'h0, bt_take}, 32'h0000_0001);
      for (int e = 0; e < 2; e++) begin
         deep_stop <= !e[0];
         sv = 1'b0;
         repeat (4) begin
            @(posedge clk);
            #1;
            sv = sv | (divider === 23'h00_0000);
         end
         chk({31'h0, sv}, 32'h0000_0001);
         @(posedge clk);
      end
      set_ctl(32'h0000_0003);
      u_cpu.wr(`BASE_TIMER_CTRL_OFS, 32'h0000_0010);
      // Warm-up after a stop from fast run: stage six, not slow ticks, feeds stage seven
      warm <= 1'b1;
      deep_stop <= 1'b1;
      @(posedge clk);
      deep_stop <= 1'b0;
      repeat (200) @(posedge clk);
      chk({17'h0, divider[22:8]}, 32'h0000_0000);
      warm <= 1'b0;
      set_ctl(32'h0000_0007);
      set_ctl(32'h0000_0005);
      q[7:0] = divider[7:0];
      repeat (50) @(posedge clk);
      chk({24'h0, divider[7:0]}, {24'h0, q[7:0]});
      set_ctl(32'h0000_0007);
      set_ctl(32'h0000_0003);
      set_ctl(32'h0000_000b);
      irq_req <= 1'b1;
      mdl = fast_run_dual;
      wait_mode(mdl);
      irq_req <= 1'b0;
      set_ctl(32'h0000_0002);
      tally_and_finish();
   end
endmodule
